// >>> logic/alert_tone_detector.sv
// Alert tone detector core with APB register file
module alert_tone_detector
  import tone_det_pkg::*;
#(
  parameter int tick_cycles  = TICK_CYCLES,
  parameter int div_48k      = DIV_48K,
  parameter int div_64k      = DIV_64K,
  parameter int div_96k      = DIV_96K,
  parameter int tone_clk_hz  = CLK_HZ
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Audio sources
  input  wire logic [15:0] sinc_sample,
  input  wire logic        sinc_valid,
  input  wire logic [15:0] digital_sample,
  input  wire logic        digital_valid,
  // Detection outputs
  output logic             detector_active,
  output logic             tone_detected,
  output logic             tone_present_evt,
  output logic             tone_absent_evt
);

  // ------------------------------------------------------------
  // Register file
  // ------------------------------------------------------------
  logic [7:0]  control_reg, rate_cfg_reg, presence_reg, absence_reg, mode_reg;
  logic [15:0] floor_reg;
  logic [15:0] coef_reg [NUM_COEF_REGS];
  logic [1:0]  status_reg;
  logic [31:0] prdata_reg;
  logic        pready_reg, pslverr_reg;

  logic [11:0] idx;
  logic        aligned, setup, wr_en;
  logic        hit_ctl, hit_floor, hit_cfg, hit_pres, hit_abs, hit_stat, hit_mode;
  logic        hit_coef, mapped;
  logic [11:0] coef_off;
  logic [3:0]  coef_sel;
  logic [31:0] rd_mux;

  assign idx       = paddr[13:2];
  assign aligned   = (paddr[15:14] == 2'h0) && (paddr[1:0] == 2'h0);
  assign setup     = psel && !penable;
  assign wr_en     = psel && penable && pready_reg && pwrite && mapped;
  assign hit_ctl   = aligned && (idx == IDX_CONTROL);
  assign hit_floor = aligned && (idx == IDX_FLOOR);
  assign hit_cfg   = aligned && (idx == IDX_RATE_CFG);
  assign hit_pres  = aligned && (idx == IDX_PRESENCE);
  assign hit_abs   = aligned && (idx == IDX_ABSENCE);
  assign hit_stat  = aligned && (idx == IDX_STATUS);
  assign hit_mode  = aligned && (idx == IDX_MODE);
  assign coef_off  = idx - IDX_COEF_BASE;
  assign coef_sel  = coef_off[3:0];
  assign hit_coef  = aligned && (idx >= IDX_COEF_BASE)
                     && (coef_off < 12'(NUM_COEF_REGS));
  assign mapped    = hit_ctl || hit_floor || hit_cfg || hit_pres || hit_abs
                     || hit_stat || hit_mode || hit_coef;

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_ctl) begin
      rd_mux = {24'h0, control_reg};
    end else if (hit_floor) begin
      rd_mux = {16'h0, floor_reg};
    end else if (hit_cfg) begin
      rd_mux = {24'h0, rate_cfg_reg};
    end else if (hit_pres) begin
      rd_mux = {24'h0, presence_reg};
    end else if (hit_abs) begin
      rd_mux = {24'h0, absence_reg};
    end else if (hit_stat) begin
      rd_mux = {30'h0, status_reg};
    end else if (hit_mode) begin
      rd_mux = {24'h0, mode_reg};
    end else if (hit_coef) begin
      rd_mux = {16'h0, coef_reg[coef_sel]};
    end
  end

  // Answer in the first access cycle; unmapped addresses flag an error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else begin
      pready_reg  <= setup;
      pslverr_reg <= setup && !mapped;
      if (setup) begin
        prdata_reg <= pwrite ? 32'h0000_0000 : rd_mux;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_reg  <= RST_CONTROL;
      floor_reg    <= RST_FLOOR;
      rate_cfg_reg <= RST_RATE_CFG;
      presence_reg <= RST_PRESENCE;
      absence_reg  <= RST_ABSENCE;
      mode_reg     <= RST_MODE;
    end else if (wr_en) begin
      if (hit_ctl) control_reg <= pwdata[7:0];
      if (hit_floor) floor_reg <= pwdata[15:0];
      if (hit_cfg) rate_cfg_reg <= pwdata[7:0];
      if (hit_pres) presence_reg <= pwdata[7:0];
      if (hit_abs) absence_reg <= pwdata[7:0];
      if (hit_mode) mode_reg <= pwdata[7:0];
    end
  end

  // Coefficient store; the prefilter should be off while it changes
  for (genvar g = 0; g < NUM_COEF_REGS; g++) begin : g_coef
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        coef_reg[g] <= FIX_COEF[g / NUM_COEF][g % NUM_COEF];
      end else if (wr_en && hit_coef && (coef_sel == 4'(g))) begin
        coef_reg[g] <= pwdata[15:0];
      end
    end
  end

  // ------------------------------------------------------------
  // Field decode
  // ------------------------------------------------------------
  logic       run, prefilter_enable, noise_tolerant, arb_mode, use_digital;
  logic [1:0] freq_tolerance_sel, rate_sel, tone_sel;
  logic [3:0] ceiling_shift;
  logic [31:0] shifted;
  logic [15:0] level_ceiling;

  assign run                = control_reg[CTL_ENABLE_BIT];
  assign prefilter_enable   = control_reg[CTL_PREFILTER_BIT];
  assign noise_tolerant     = control_reg[CTL_NOISE_BIT];
  assign freq_tolerance_sel = control_reg[CTL_TOL_LSB +: 2];
  assign use_digital        = rate_cfg_reg[CFG_SRC_BIT];
  assign rate_sel           = rate_cfg_reg[CFG_RATE_LSB +: 2];
  assign ceiling_shift      = rate_cfg_reg[CFG_SHIFT_LSB +: 4];
  assign arb_mode           = mode_reg[MODE_ARB_BIT];
  // Fixed mode is always dual tone
  assign tone_sel           = arb_mode ? mode_reg[MODE_SEL_LSB +: 2] : SEL_DUAL;
  assign shifted            = {16'h0, floor_reg} << ceiling_shift;
  assign level_ceiling      = (!floor_reg[15] && shifted >= {16'h0, LEVEL_FULL_SCALE})
                              ? LEVEL_FULL_SCALE : shifted[15:0];

  // ------------------------------------------------------------
  // Input selection and sampling clock
  // ------------------------------------------------------------
  logic signed [15:0] in_sample_reg;
  logic        [15:0] src_sample;
  logic               src_valid, src_rise, sample_tick_reg;
  logic        [12:0] div_cnt_reg, div_limit;

  assign src_sample = use_digital ? digital_sample : sinc_sample;
  assign src_valid  = use_digital ? digital_valid : sinc_valid;
  assign src_rise   = src_valid && in_sample_reg[15] && !src_sample[15];
  assign div_limit  = (rate_sel == RATE_ALIGN_64K) ? 13'(div_64k - 1) :
                      (rate_sel[1])                 ? 13'(div_96k - 1) :
                                                       13'(div_48k - 1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_sample_reg   <= '0;
      div_cnt_reg     <= '0;
      sample_tick_reg <= 1'b0;
    end else begin
      if (src_valid) in_sample_reg <= src_sample;
      // Aligned modes restart the divider on each rising crossing
      if (!run || (rate_sel != RATE_FREE_48K && src_rise) || div_cnt_reg >= div_limit) begin
        div_cnt_reg <= '0;
      end else begin
        div_cnt_reg <= div_cnt_reg + 13'h1;
      end
      sample_tick_reg <= run && (div_cnt_reg >= div_limit);
    end
  end

  // ------------------------------------------------------------
  // Band filters, level window, frequency check
  // ------------------------------------------------------------
  logic [1:0] band_raw;

  for (genvar b = 0; b < 2; b++) begin : g_band
    biquad_if bq_if ();
    logic [15:0]        abs_y;
    logic [15:0]        peak_reg;
    logic [PEAK_WIN_BITS-1:0] win_cnt_reg;
    logic               level_ok_reg, freq_ok_reg, prev_neg_reg, raw_reg, strike_reg;
    logic [19:0]        per_cnt_reg;
    logic [19:0]        pmin_tab [4];
    logic [19:0]        pmax_tab [4];
    logic               crossing, in_band, good;

    assign bq_if.clear = !run || !prefilter_enable;
    assign bq_if.step  = sample_tick_reg;
    assign bq_if.x     = in_sample_reg;
    for (genvar k = 0; k < NUM_COEF; k++) begin : g_k
      assign bq_if.coef[k] = arb_mode ? coef_reg[b * NUM_COEF + k]
                                      : FIX_COEF[b][k];
    end
    for (genvar t = 0; t < 4; t++) begin : g_t
      assign pmin_tab[t] = 20'(tone_clk_hz / BAND_MAX_HZ[b][t]);
      assign pmax_tab[t] = 20'(tone_clk_hz / BAND_MIN_HZ[b][t]);
    end

    biquad_section u_bq (
      .pclk    (pclk),
      .presetn (presetn),
      .bq      (bq_if.filt)
    );

    assign abs_y    = bq_if.y[15] ? ((bq_if.y == 16'sh8000) ? LEVEL_FULL_SCALE
                                     : 16'(-bq_if.y)) : bq_if.y;
    assign crossing = sample_tick_reg && prev_neg_reg && !bq_if.y[15];
    assign in_band  = (per_cnt_reg >= pmin_tab[freq_tolerance_sel])
                      && (per_cnt_reg <= pmax_tab[freq_tolerance_sel]);
    assign good     = level_ok_reg && (arb_mode || freq_ok_reg);
    assign band_raw[b] = raw_reg;

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        peak_reg     <= '0;
        win_cnt_reg  <= '0;
        level_ok_reg <= 1'b0;
        prev_neg_reg <= 1'b0;
        per_cnt_reg  <= '0;
        freq_ok_reg  <= 1'b0;
      end else if (bq_if.clear) begin
        peak_reg     <= '0;
        win_cnt_reg  <= '0;
        level_ok_reg <= 1'b0;
        prev_neg_reg <= 1'b0;
        per_cnt_reg  <= '0;
        freq_ok_reg  <= 1'b0;
      end else begin
        per_cnt_reg <= crossing ? 20'h00001
                     : (&per_cnt_reg) ? per_cnt_reg : per_cnt_reg + 20'h00001;
        if (crossing) freq_ok_reg <= in_band;
        else if (&per_cnt_reg) freq_ok_reg <= 1'b0;
        if (sample_tick_reg) begin
          prev_neg_reg <= bq_if.y[15];
          win_cnt_reg  <= win_cnt_reg + 1'b1;
          if (&win_cnt_reg) begin
            level_ok_reg <= ($signed(abs_y) >= $signed(floor_reg))
                            && ($signed(abs_y) <= $signed(level_ceiling))
                            && ($signed(peak_reg) >= $signed(floor_reg))
                            && ($signed(peak_reg) <= $signed(level_ceiling));
            peak_reg     <= '0;
          end else if (abs_y > peak_reg) begin
            peak_reg <= abs_y;
          end
        end
      end
    end

    // A tolerant detector forgives one bad window before dropping out
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        raw_reg    <= 1'b0;
        strike_reg <= 1'b0;
      end else if (bq_if.clear) begin
        raw_reg    <= 1'b0;
        strike_reg <= 1'b0;
      end else if (sample_tick_reg && (&win_cnt_reg)) begin
        if (good) begin
          raw_reg    <= 1'b1;
          strike_reg <= 1'b0;
        end else if (noise_tolerant && !strike_reg) begin
          strike_reg <= 1'b1;
        end else begin
          raw_reg    <= 1'b0;
          strike_reg <= 1'b0;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Half millisecond tick and presence/absence qualifiers
  // ------------------------------------------------------------
  logic [16:0] tick_cnt_reg;
  logic        tick_reg;
  logic [1:0]  q_in, det, on_hit, off_hit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_reg <= '0;
      tick_reg     <= 1'b0;
    end else begin
      tick_reg     <= run && (tick_cnt_reg == 17'(tick_cycles - 1));
      tick_cnt_reg <= (!run || tick_cnt_reg == 17'(tick_cycles - 1))
                      ? 17'h00000 : tick_cnt_reg + 17'h00001;
    end
  end

  assign q_in[0] = (tone_sel == SEL_LOW || tone_sel == SEL_SPLIT) ? band_raw[0] :
                   (tone_sel == SEL_HIGH) ? band_raw[1] : (band_raw[0] && band_raw[1]);
  assign q_in[1] = (tone_sel == SEL_SPLIT) && band_raw[1];

  for (genvar q = 0; q < 2; q++) begin : g_qual
    qual_state_t state_reg;
    logic [7:0]  cnt_reg;
    logic [8:0]  cnt_inc;

    assign cnt_inc    = {1'b0, cnt_reg} + 9'h001;
    assign det[q]     = (state_reg == Q_PRESENT);
    assign on_hit[q]  = tick_reg && (state_reg == Q_ABSENT) && q_in[q]
                        && (cnt_inc >= {1'b0, presence_reg});
    assign off_hit[q] = tick_reg && (state_reg == Q_PRESENT) && !q_in[q]
                        && (cnt_inc >= {1'b0, absence_reg});

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        state_reg <= Q_ABSENT;
        cnt_reg   <= '0;
      end else if (!run) begin
        state_reg <= Q_ABSENT;
        cnt_reg   <= '0;
      end else if (tick_reg) begin
        case (state_reg)
          Q_ABSENT: begin
            if (!q_in[q]) begin
              cnt_reg <= '0;
            end else if (on_hit[q]) begin
              state_reg <= Q_PRESENT;
              cnt_reg   <= '0;
            end else begin
              cnt_reg <= cnt_inc[7:0];
            end
          end
          Q_PRESENT: begin
            if (q_in[q]) begin
              cnt_reg <= '0;
            end else if (off_hit[q]) begin
              state_reg <= Q_ABSENT;
              cnt_reg   <= '0;
            end else begin
              cnt_reg <= cnt_inc[7:0];
            end
          end
          default: begin
            state_reg <= Q_ABSENT;
          end
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // Status and event outputs
  // ------------------------------------------------------------
  logic tone_detected_reg, present_evt_reg, absent_evt_reg, active_reg;
  // Events come from the state edge so they line up with tone_detected
  logic [1:0] det_d_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_reg        <= 2'h0;
      tone_detected_reg <= 1'b0;
      present_evt_reg   <= 1'b0;
      absent_evt_reg    <= 1'b0;
      active_reg        <= 1'b0;
      det_d_reg         <= 2'h0;
    end else begin
      det_d_reg         <= det;
      status_reg        <= {(tone_sel == SEL_SPLIT) && det[1], det[0]};
      tone_detected_reg <= |det;
      present_evt_reg   <= control_reg[CTL_ON_EVT_BIT] && run && (|(det & ~det_d_reg));
      absent_evt_reg    <= control_reg[CTL_OFF_EVT_BIT] && run && (|(~det & det_d_reg));
      active_reg        <= run;
    end
  end

  assign prdata           = prdata_reg;
  assign pready           = pready_reg;
  assign pslverr          = pslverr_reg;
  assign detector_active  = active_reg;
  assign tone_detected    = tone_detected_reg;
  assign tone_present_evt = present_evt_reg;
  assign tone_absent_evt  = absent_evt_reg;

endmodule

// >>> logic/tone_det_pkg.sv
// Constants, types and register map of the alert tone detector
package tone_det_pkg;

  // ------------------------------------------------------------
  // Clock and timing
  // ------------------------------------------------------------
  localparam int CLK_HZ        = 200_000_000;
  localparam int TICK_TIME_US  = 500;
  localparam int TICK_CYCLES   = TICK_TIME_US * (CLK_HZ / 1_000_000);
  localparam int RATE_48K_HZ   = 48_000;
  localparam int RATE_64K_HZ   = 64_000;
  localparam int RATE_96K_HZ   = 96_000;
  localparam int DIV_48K       = CLK_HZ / RATE_48K_HZ;
  localparam int DIV_64K       = CLK_HZ / RATE_64K_HZ;
  localparam int DIV_96K       = CLK_HZ / RATE_96K_HZ;

  // ------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ------------------------------------------------------------
  localparam logic [11:0] IDX_CONTROL   = 12'h200;
  localparam logic [11:0] IDX_FLOOR     = 12'h201;
  localparam logic [11:0] IDX_RATE_CFG  = 12'h203;
  localparam logic [11:0] IDX_PRESENCE  = 12'h204;
  localparam logic [11:0] IDX_ABSENCE   = 12'h205;
  localparam logic [11:0] IDX_STATUS    = 12'h206;
  localparam logic [11:0] IDX_MODE      = 12'h207;
  localparam logic [11:0] IDX_COEF_BASE = 12'h210;
  localparam int          NUM_COEF      = 5;
  localparam int          NUM_COEF_REGS = 2 * NUM_COEF;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [7:0]  RST_CONTROL  = 8'h40;
  localparam logic [15:0] RST_FLOOR    = 16'h0000;
  localparam logic [7:0]  RST_RATE_CFG = 8'h11;
  localparam logic [7:0]  RST_PRESENCE = 8'h40;
  localparam logic [7:0]  RST_ABSENCE  = 8'h20;
  localparam logic [7:0]  RST_MODE     = 8'h10;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int CTL_ENABLE_BIT    = 7;
  localparam int CTL_PREFILTER_BIT = 6;
  localparam int CTL_ON_EVT_BIT    = 5;
  localparam int CTL_OFF_EVT_BIT   = 4;
  localparam int CTL_NOISE_BIT     = 2;
  localparam int CTL_TOL_LSB       = 0;
  localparam int CFG_SRC_BIT       = 6;
  localparam int CFG_RATE_LSB      = 4;
  localparam int CFG_SHIFT_LSB     = 0;
  localparam int MODE_ARB_BIT      = 7;
  localparam int MODE_SEL_LSB      = 5;

  // ------------------------------------------------------------
  // Field encodings and levels
  // ------------------------------------------------------------
  localparam logic [1:0]  SEL_DUAL        = 2'h0;
  localparam logic [1:0]  SEL_LOW         = 2'h1;
  localparam logic [1:0]  SEL_HIGH        = 2'h2;
  localparam logic [1:0]  SEL_SPLIT       = 2'h3;
  localparam logic [1:0]  RATE_FREE_48K   = 2'h0;
  localparam logic [1:0]  RATE_ALIGN_48K  = 2'h1;
  localparam logic [1:0]  RATE_ALIGN_64K  = 2'h2;
  localparam logic [15:0] LEVEL_FULL_SCALE = 16'h7FFF;
  localparam int          PEAK_WIN_BITS   = 6;

  // Band 0 is the low tone, band 1 the high tone; index is the tolerance code
  localparam int BAND_MIN_HZ [2][4] = '{'{2087, 2109, 2087, 2066},
                                        '{2695, 2722, 2695, 2667}};
  localparam int BAND_MAX_HZ [2][4] = '{'{2176, 2151, 2176, 2193},
                                        '{2805, 2777, 2805, 2832}};

  // Fixed bandpass coefficients, Q2.14, order b0 b1 b2 a1 a2, at 48 kHz
  localparam logic [15:0] FIX_COEF [2][5] = '{
    '{16'h00BC, 16'h0000, 16'hFF44, 16'h8644, 16'h3E87},
    '{16'h0199, 16'h0000, 16'hFE67, 16'h8B31, 16'h3CCE}};

  typedef enum logic {Q_ABSENT, Q_PRESENT} qual_state_t;

endpackage

// >>> logic/biquad_if.sv
// Connection between the detector core and one biquad section
interface biquad_if;
  logic               clear;
  logic               step;
  logic signed [15:0] x;
  logic        [15:0] coef [5];
  logic signed [15:0] y;
  modport ctrl (output clear, output step, output x, output coef, input y);
  modport filt (input clear, input step, input x, input coef, output y);
endinterface

// >>> logic/biquad_section.sv
// One direct form I biquad section with Q2.14 coefficients
module biquad_section
  import tone_det_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Filter connection
  biquad_if.filt   bq
);

  logic signed [15:0] x1_reg, x2_reg, y1_reg, y2_reg;
  logic signed [31:0] p0, p1, p2, p3, p4;
  logic signed [34:0] acc;
  logic signed [34:0] scaled;
  logic signed [15:0] sat;

  assign p0     = $signed(bq.coef[0]) * bq.x;
  assign p1     = $signed(bq.coef[1]) * x1_reg;
  assign p2     = $signed(bq.coef[2]) * x2_reg;
  assign p3     = $signed(bq.coef[3]) * y1_reg;
  assign p4     = $signed(bq.coef[4]) * y2_reg;
  assign acc    = 35'(p0) + 35'(p1) + 35'(p2) - 35'(p3) - 35'(p4);
  assign scaled = acc >>> 14;
  // Clip rather than wrap, so a hot input cannot flip the peak sign
  assign sat    = (scaled > 35'sd32767)  ? 16'sh7FFF :
                  (scaled < -35'sd32768) ? 16'sh8000 : scaled[15:0];
  assign bq.y   = y1_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      x1_reg <= '0;
      x2_reg <= '0;
      y1_reg <= '0;
      y2_reg <= '0;
    end else if (bq.clear) begin
      x1_reg <= '0;
      x2_reg <= '0;
      y1_reg <= '0;
      y2_reg <= '0;
    end else if (bq.step) begin
      x1_reg <= bq.x;
      x2_reg <= x1_reg;
      y1_reg <= sat;
      y2_reg <= y1_reg;
    end
  end

endmodule

// >>> tb/tone_src_model.sv
// Tone pair source feeding the sinc and digital audio paths
module tone_src_model (
  // Control
  input  wire logic        pclk,
  input  wire logic        tone_on,
  input  wire logic        use_dig,
  // Audio paths
  output logic      [15:0] sinc_sample,
  output logic             sinc_valid,
  output logic      [15:0] digital_sample,
  output logic             digital_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  int          hc = 0;
  int          lc = 0;
  logic        v  = 1'b0;
  logic [15:0] s;
  // Square pair near the two band centres at the scaled clock
  assign s = tone_on ? 16'((hc < 70 ? 4096 : -4096) + (lc < 90 ? 4096 : -4096)) : 16'h0000;
  always_ff @(posedge pclk) begin
    hc <= (hc + 1) % 140;
    lc <= (lc + 1) % 180;
    v  <= ~v;
  end
  // Idle path carries silence, not the last tone value
  assign sinc_valid     = v;
  assign digital_valid  = v;
  assign sinc_sample    = use_dig ? 16'h0000 : s;
  assign digital_sample = use_dig ? s : 16'h0000;
endmodule

// >>> tb/alert_tone_detector_properties.sv
// Port checks of the alert tone detector
module alert_tone_detector_properties (
  // Clock, reset and bus
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Detection
  input wire logic        detector_active,
  input wire logic        tone_detected,
  input wire logic        tone_present_evt,
  input wire logic        tone_absent_evt
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence setup_s; psel && !penable; endsequence
  sequence rd_s; psel && penable && pready && !pwrite; endsequence
  AST_READY_ONE: assert property (setup_s |=> pready ##1 !pready)
    else $error("pready not a one cycle answer");
  AST_BAD_ADDR: assert property (rd_s and paddr[1:0] != 2'h0 |-> pslverr && prdata == 32'h0)
    else $error("misaligned read not refused");
  AST_STATUS_BITS: assert property (rd_s and paddr == 16'h0818 |-> prdata[31:2] == 30'h0)
    else $error("status upper bits set");
  AST_FLOOR_BITS: assert property (rd_s and paddr == 16'h0804 |-> prdata[31:16] == 16'h0)
    else $error("floor upper bits set");
  AST_PRESENT_DET: assert property (tone_present_evt |-> tone_detected)
    else $error("present event without detection");
  AST_PRESENT_PULSE: assert property (tone_present_evt |=> !tone_present_evt)
    else $error("present event too long");
  AST_ABSENT_PULSE: assert property (tone_absent_evt |=> !tone_absent_evt)
    else $error("absent event too long");
  AST_NO_CLASH: assert property (tone_absent_evt |-> !tone_present_evt)
    else $error("present and absent together");
  AST_OFF_CLEAR: assert property (!detector_active [*3] |-> !tone_detected && !tone_present_evt)
    else $error("detection while powered down");
endmodule
bind alert_tone_detector alert_tone_detector_properties alert_tone_detector_properties_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .detector_active(detector_active), .tone_detected(tone_detected),
  .tone_present_evt(tone_present_evt), .tone_absent_evt(tone_absent_evt));

// >>> tb/test_alert_tone_detector.sv
// Self-checking bench of the alert tone detector
module test_alert_tone_detector import tone_det_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        tone_on = 1'b0, use_dig = 1'b1, pready, pslverr, act, det, pevt, aevt, sv, dv, err;
  logic [15:0] paddr = 16'h0000, ss, ds;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [31:0] mdl [int] = '{'h200: 32'h40, 'h201: 32'h0, 'h203: 32'h11, 'h204: 32'h40,
    'h205: 32'h20, 'h206: 32'h0, 'h207: 32'h10, 'h210: 32'h00BC};
  logic [31:0] msk [int] = '{'h200: 32'hF7, 'h201: 32'hFFFF, 'h203: 32'h7F, 'h204: 32'hFF,
    'h205: 32'hFF, 'h206: 32'h0};
  int          mismatches = 0, total_checks = 0, n, pcnt = 0;
  alert_tone_detector #(.tick_cycles(20), .div_48k(8), .div_64k(6), .div_96k(4),
    .tone_clk_hz(384000)) alert_tone_detector_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sinc_sample(ss),
    .sinc_valid(sv), .digital_sample(ds), .digital_valid(dv), .detector_active(act),
    .tone_detected(det), .tone_present_evt(pevt), .tone_absent_evt(aevt));
  tone_src_model tone_src_model_inst (.pclk(pclk), .tone_on(tone_on), .use_dig(use_dig),
    .sinc_sample(ss), .sinc_valid(sv), .digital_sample(ds), .digital_valid(dv));
  initial begin
    forever #2.5 pclk = ~pclk;
  end
  always @(posedge pclk) if (pevt === 1'b1) pcnt++;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude;
    $display("Checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Wait bounded; a hang is a mismatch
  task automatic wait_hi(ref logic s);
    for (n = 0; n < 30000 && s !== 1'b1; n++) @(posedge pclk);
    if (n == 30000) begin
      mismatches++;
      conclude();
    end
  endtask
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    wait_hi(pready);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input int i, input logic [31:0] d);
    apb(1'b1, {2'h0, 12'(i), 2'h0}, d);
    if (msk.exists(i)) mdl[i] = d & msk[i];
  endtask
  task automatic rdc(input int i);
    apb(1'b0, {2'h0, 12'(i), 2'h0}, 32'h0);
    check(rd, mdl[i]);
  endtask
  initial begin
    void'($urandom(38772));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (mdl[i]) rdc(i);
    foreach (msk[i]) begin
      wr(i, $urandom & 32'hFFFFFF77);
      rdc(i);
    end
    apb(1'b0, 16'h0801, 32'h0);
    check({31'h0, err}, 32'h1);
    wr(IDX_FLOOR, 32'h0100);
    wr(IDX_PRESENCE, 32'h02);
    wr(IDX_ABSENCE, 32'h02);
    wr(IDX_RATE_CFG, 32'h08);
    tone_on <= 1'b1;
    wr(IDX_CONTROL, 32'hF4);
    @(posedge pclk);
    check({31'h0, act}, 32'h1);
    repeat (4000) @(posedge pclk);
    check({31'h0, det}, 32'h0);
    wr(IDX_RATE_CFG, 32'h48);
    wait_hi(pevt);
    mdl[IDX_STATUS] = 32'h1;
    rdc(IDX_STATUS);
    tone_on <= 1'b0;
    wait_hi(aevt);
    check({31'h0, det}, 32'h0);
    mdl[IDX_STATUS] = 32'h0;
    rdc(IDX_STATUS);
    wr(IDX_CONTROL, 32'hC4);
    tone_on <= 1'b1;
    wait_hi(det);
    check(pcnt, 32'h1);
    wr(IDX_CONTROL, 32'h00);
    repeat (3) @(posedge pclk);
    check({30'h0, act, det}, 32'h0);
    wr('h210, 32'h0123);
    mdl['h210] = 32'h0123;
    rdc('h210);
    conclude();
  end
endmodule
